// ==== verilog/config_glue_pkg.sv ====
package config_glue_pkg;

  // ---------------------------------------------------------------
  // Nonvolatile locations
  // ---------------------------------------------------------------
  localparam logic [23:0] OPTION_BYTE_ADDR  = 24'hfffe0e;
  localparam logic [23:0] REF_SUPPLY_ADDR   = 24'h1fc040;
  localparam logic [23:0] REF_EXTERNAL_ADDR = 24'h1fc042;

  // ---------------------------------------------------------------
  // Option byte fields
  // ---------------------------------------------------------------
  localparam int OPTION_RATE_LSB   = 0;
  localparam int OPTION_RATE_MSB   = 2;
  localparam int OPTION_WINDOW_POS = 3;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [2:0] RATE_RESET         = 3'h0;
  localparam logic       WINDOW_RESET       = 1'b0;
  localparam logic [7:0] TRACE_READ_DATA    = 8'h00;
  localparam logic [1:0] CAP_SEL_PIN        = 2'h0;
  localparam logic [1:0] CAP_SEL_SERIAL0    = 2'h1;
  localparam logic [1:0] CAP_SEL_SERIAL1    = 2'h2;
  localparam int         REF_WIDTH          = 12;
  localparam int         REF_PAD            = 4;

  typedef enum logic [1:0] {
    LOAD_REQUEST,
    LOAD_WAIT,
    LOAD_DONE
  } load_state_e;

  typedef struct packed {
    logic [23:0] addr;
    logic        req;
  } nv_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } nv_rsp_s;

  typedef struct packed {
    logic [2:0] watchdog_rate_field;
    logic       watchdog_window_bit;
    logic       loaded;
  } watchdog_cfg_s;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } debug_rsp_s;

  typedef struct packed {
    load_state_e   state;
    nv_req_s       nv_req;
    watchdog_cfg_s wd;
    debug_rsp_s    dbg;
    logic          capture3_in;
    logic          io_supply_lvr_enable;
  } glue_state_s;

endpackage

// ==== verilog/device_level_config_glue.sv ====
module device_level_config_glue #(
  parameter logic [11:0] REF_SUPPLY_RESULT   = 12'h000,
  parameter logic [11:0] REF_EXTERNAL_RESULT = 12'h000
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  output logic      [23:0]                   nv_addr,
  output logic                               nv_read_req,
  input  wire config_glue_pkg::nv_rsp_s      nv_rsp,
  output config_glue_pkg::watchdog_cfg_s     watchdog_cfg,
  input  wire logic                          trace_buffer_read_cmd,
  output config_glue_pkg::debug_rsp_s        debug_rsp,
  input  wire logic [1:0]                    capture3_input_select,
  input  wire logic                          timer0_ch3_pin,
  input  wire logic                          serial0_rx,
  input  wire logic                          serial1_rx,
  output logic                               timer0_capture3_in,
  input  wire logic                          regulator_reduced_power,
  output logic                               io_supply_lvr_enable
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Pins are asynchronous; two stages before the capture mux.
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {serial1_rx, serial0_rx, timer0_ch3_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Info-row reference words
  // ---------------------------------------------------------------
  // Left-justified: low nibble of each 16-bit word reads zero.
  function automatic logic [7:0] info_row_byte(input logic [23:0] a);
    logic [15:0] w;
    w = 16'h0000;
    if (a[23:1] == config_glue_pkg::REF_SUPPLY_ADDR[23:1]) begin
      w = {REF_SUPPLY_RESULT, {config_glue_pkg::REF_PAD{1'b0}}};
    end else if (a[23:1] == config_glue_pkg::REF_EXTERNAL_ADDR[23:1]) begin
      w = {REF_EXTERNAL_RESULT, {config_glue_pkg::REF_PAD{1'b0}}};
    end
    // Big-endian: even address holds the upper byte
    return a[0] ? w[7:0] : w[15:8];
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  config_glue_pkg::glue_state_s s_q;
  config_glue_pkg::glue_state_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.nv_req.req = 1'b0;
    case (s_q.state)
      config_glue_pkg::LOAD_REQUEST: begin
        s_d.nv_req.addr = config_glue_pkg::OPTION_BYTE_ADDR;
        s_d.nv_req.req  = 1'b1;
        s_d.state       = config_glue_pkg::LOAD_WAIT;
      end
      config_glue_pkg::LOAD_WAIT: begin
        if (nv_rsp.valid) begin
          s_d.wd.watchdog_rate_field = ~nv_rsp.data[config_glue_pkg::OPTION_RATE_MSB:
                                                    config_glue_pkg::OPTION_RATE_LSB];
          s_d.wd.watchdog_window_bit =
            ~nv_rsp.data[config_glue_pkg::OPTION_WINDOW_POS];
          s_d.wd.loaded = 1'b1;
          s_d.state     = config_glue_pkg::LOAD_DONE;
        end
      end
      config_glue_pkg::LOAD_DONE: begin
        s_d.state = config_glue_pkg::LOAD_DONE;
      end
      default: begin
        s_d.state = config_glue_pkg::LOAD_REQUEST;
      end
    endcase

    // No trace buffer exists, so every read answers zero
    s_d.dbg.valid = trace_buffer_read_cmd;
    s_d.dbg.data  = config_glue_pkg::TRACE_READ_DATA;

    case (capture3_input_select)
      config_glue_pkg::CAP_SEL_SERIAL0: s_d.capture3_in = pin_sync_q[1];
      config_glue_pkg::CAP_SEL_SERIAL1: s_d.capture3_in = pin_sync_q[2];
      config_glue_pkg::CAP_SEL_PIN:     s_d.capture3_in = pin_sync_q[0];
      // Reserved code falls back to the pin, the safest routing
      default:                          s_d.capture3_in = pin_sync_q[0];
    endcase

    s_d.io_supply_lvr_enable = ~regulator_reduced_power;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q.state                  <= config_glue_pkg::LOAD_REQUEST;
      s_q.nv_req                 <= '0;
      s_q.wd.watchdog_rate_field <= config_glue_pkg::RATE_RESET;
      s_q.wd.watchdog_window_bit <= config_glue_pkg::WINDOW_RESET;
      s_q.wd.loaded              <= 1'b0;
      s_q.dbg                    <= '0;
      s_q.capture3_in            <= 1'b0;
      s_q.io_supply_lvr_enable   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Info-row read port
  // ---------------------------------------------------------------
  // Reference words are looked up from the option-byte fetch address
  // s_q.nv_req.addr; info_row_data_q drives no output port.
  logic [7:0] info_row_data_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      info_row_data_q <= 8'h00;
    end else begin
      info_row_data_q <= info_row_byte(s_q.nv_req.addr);
    end
  end

  assign nv_addr              = s_q.nv_req.addr;
  assign nv_read_req          = s_q.nv_req.req;
  assign watchdog_cfg         = s_q.wd;
  assign debug_rsp            = s_q.dbg;
  assign timer0_capture3_in   = s_q.capture3_in;
  assign io_supply_lvr_enable = s_q.io_supply_lvr_enable;

endmodule

// ==== verification/nv_option_model.sv ====
// ------
// Nonvolatile read port
// ------
module nv_option_model (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic [23:0]              nv_addr,
  input  wire logic                     nv_read_req,
  input  wire logic [7:0]               option_byte,
  input  wire logic [3:0]               delay,
  output config_glue_pkg::nv_rsp_s      nv_rsp
);
  int cnt = -1;
  initial nv_rsp = '0;
  // Idle data toggles so that a stale byte is never mistaken for the answer
  always @(posedge clk) begin
    nv_rsp.valid <= 1'b0;
    nv_rsp.data  <= ~nv_rsp.data;
    if (reset) cnt = -1;
    else if (nv_read_req && nv_addr == config_glue_pkg::OPTION_BYTE_ADDR) cnt = delay;
    else if (cnt > 0) cnt--;
    else if (cnt == 0) begin
      nv_rsp <= {option_byte, 1'b1};
      cnt = -1;
    end
  end
endmodule

// ==== verification/glue_asserts.sv ====
// ------
// Port checks
// ------
module glue_asserts (
  input wire logic                           clk,
  input wire logic                           reset,
  input wire logic [23:0]                    nv_addr,
  input wire logic                           nv_read_req,
  input wire config_glue_pkg::nv_rsp_s       nv_rsp,
  input wire config_glue_pkg::watchdog_cfg_s watchdog_cfg,
  input wire logic                           trace_buffer_read_cmd,
  input wire config_glue_pkg::debug_rsp_s    debug_rsp,
  input wire logic [1:0]                     capture3_input_select,
  input wire logic                           timer0_ch3_pin,
  input wire logic                           serial0_rx,
  input wire logic                           serial1_rx,
  input wire logic                           timer0_capture3_in,
  input wire logic                           regulator_reduced_power,
  input wire logic                           io_supply_lvr_enable
);
  logic src;
  assign src = capture3_input_select == 2'h1 ? serial0_rx :
               capture3_input_select == 2'h2 ? serial1_rx : timer0_ch3_pin;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Five quiet samples cover the two-flop synchroniser plus the output flop
  sequence s_steady;
    ($stable(src) && $stable(capture3_input_select)) [*5];
  endsequence
  AST_REQ: assert property (
    $fell(reset) |=> nv_read_req && nv_addr == config_glue_pkg::OPTION_BYTE_ADDR)
    else $error("option read not issued after reset");
  AST_PULSE: assert property (nv_read_req |=> !nv_read_req)
    else $error("option read repeated");
  AST_RATE: assert property (
    $rose(watchdog_cfg.loaded) |-> $past(nv_rsp.valid) &&
    watchdog_cfg.watchdog_rate_field == ~$past(nv_rsp.data[2:0]))
    else $error("watchdog rate not inverted option bits");
  AST_WIN: assert property (
    $rose(watchdog_cfg.loaded) |-> watchdog_cfg.watchdog_window_bit == !$past(nv_rsp.data[3]))
    else $error("window bit not inverted option bit");
  AST_HOLD: assert property (watchdog_cfg.loaded |=> $stable(watchdog_cfg))
    else $error("watchdog settings changed after load");
  AST_TRACE: assert property (
    trace_buffer_read_cmd |=> debug_rsp.valid && debug_rsp.data == 8'h00)
    else $error("trace read answer wrong");
  AST_ROUTE: assert property (s_steady |-> timer0_capture3_in == src)
    else $error("capture input source wrong");
  AST_LVR: assert property (
    1'b1 |=> io_supply_lvr_enable == !$past(regulator_reduced_power))
    else $error("io supply monitor gate wrong");
endmodule
bind device_level_config_glue glue_asserts glue_asserts_i (.clk, .reset, .nv_addr,
  .nv_read_req, .nv_rsp, .watchdog_cfg, .trace_buffer_read_cmd, .debug_rsp,
  .capture3_input_select, .timer0_ch3_pin, .serial0_rx, .serial1_rx, .timer0_capture3_in,
  .regulator_reduced_power, .io_supply_lvr_enable);

// ==== verification/device_level_config_glue_tb.sv ====
module device_level_config_glue_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Bench
  // ------
  logic clk = 0, reset = 1, cmd = 0, pin = 0, rx0 = 0, rx1 = 0, rrp = 0;
  logic [1:0]  sel = 2'h0;
  logic [7:0]  opt = 8'h00;
  logic [3:0]  dly = 4'h0;
  logic [23:0] addr;
  logic        req, cap, low_voltage_reset;
  config_glue_pkg::nv_rsp_s       rsp;
  config_glue_pkg::watchdog_cfg_s wd;
  config_glue_pkg::debug_rsp_s    dbg;
  int failures = 0, n_tests = 0;
  always #10 clk = ~clk;
  device_level_config_glue device_level_config_glue_i (.clk, .reset, .nv_addr(addr),
    .nv_read_req(req), .nv_rsp(rsp), .watchdog_cfg(wd), .trace_buffer_read_cmd(cmd),
    .debug_rsp(dbg), .capture3_input_select(sel), .timer0_ch3_pin(pin), .serial0_rx(rx0),
    .serial1_rx(rx1), .timer0_capture3_in(cap), .regulator_reduced_power(rrp),
    .io_supply_lvr_enable(low_voltage_reset));
  nv_option_model nv_option_model_i (.clk, .reset, .nv_addr(addr), .nv_read_req(req),
    .option_byte(opt), .delay(dly), .nv_rsp(rsp));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Upper option bits are set on purpose: they must not leak into the fields
  task automatic load_test(input logic [7:0] o, input logic [3:0] d);
    int k;
    opt = o;
    dly = d;
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    for (k = 0; k < 40 && wd.loaded !== 1'b1; k++) @(negedge clk);
    if (k == 40) begin
      failures++;
      tally_and_finish();
    end
    chk({4'h0, wd}, {4'h0, ~o[2:0], ~o[3], 1'b1});
    $display("load test %h done", o);
  endtask
  task automatic trace_test;
    cmd = 1'b1;
    repeat (3) begin
      @(negedge clk);
      chk(dbg, 9'h001);
    end
    cmd = 1'b0;
    @(negedge clk);
    chk(dbg, 9'h000);
    $display("trace test done");
  endtask
  task automatic route_test;
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 3; p++) begin
        sel = s[1:0];
        {pin, rx0, rx1} = 3'h4 >> p;
        repeat (6) @(negedge clk);
        chk({8'h0, cap}, {8'h0, (s == 1) ? rx0 : (s == 2) ? rx1 : pin});
      end
    end
    $display("route test done");
  endtask
  task automatic lvr_test;
    for (int v = 1; v >= 0; v--) begin
      rrp = v[0];
      @(negedge clk);
      chk({8'h0, low_voltage_reset}, {8'h0, ~v[0]});
    end
    $display("lvr test done");
  endtask
  initial begin
    for (int i = 0; i < 16; i++) load_test({4'ha, i[3:0]}, i[3:0]);
    trace_test();
    route_test();
    lvr_test();
    tally_and_finish();
  end
endmodule
